// file: rtl/sleep_power_reduction_ctrl.sv
`timescale 1ns/1ps
module sleep_power_reduction_ctrl #(
   parameter int stretch_width = 16
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire logic                     reset_source,
   input  wire logic [stretch_width-1:0] fuse_stretch_count,
   input  wire logic [stretch_width-1:0] fuse_startup_count,
   input  wire logic                     sleep_instr,
   input  wire logic                     wake_event,
   input  wire logic                     debug_enable_fuse,
   input  wire logic                     watchdog_enable,
   input  wire logic                     detector_level_fuses,
   input  wire logic                     comparator_enable,
   input  wire logic                     comparator_uses_ref,
   input  wire logic                     converter_enable,
   input  wire logic [7:0]               wake_pin_mask,
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   output logic                          internal_reset,
   output logic                          port_reset,
   output logic                          cpu_halt,
   output logic                          main_clock_run,
   output logic                          io_clock_run,
   output logic                          converter_clock_run,
   output logic                          watchdog_run,
   output logic                          detector_on,
   output logic                          comparator_on,
   output logic                          reference_on,
   output logic [7:0]                    input_buffer_en,
   output logic                          pullup_disable,
   output logic                          gate_two_wire,
   output logic                          gate_timer_zero,
   output logic                          gate_timer_one,
   output logic                          gate_serial_periph,
   output logic                          gate_converter
);
   // =========================================
   // reset source synchroniser and stretch
   logic                     src_meta_q;
   logic                     src_sync_q;
   logic [stretch_width-1:0] stretch_q;
   logic [stretch_width-1:0] stretch_d;
   logic                     int_rst_q;
   logic                     port_rst_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         src_meta_q <= 1'b1;
         src_sync_q <= 1'b1;
      end else begin
         src_meta_q <= reset_source;
         src_sync_q <= src_meta_q;
      end
   end

   // load fuse count while a source is active, count down after
   assign stretch_d = src_sync_q ? fuse_stretch_count :
                      (stretch_q != '0) ? stretch_q - 1'b1 : stretch_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stretch_q <= '1;
         int_rst_q <= 1'b1;
      end else begin
         stretch_q <= stretch_d;
         int_rst_q <= src_sync_q || (stretch_q != '0);
      end
   end

   // ports follow any reset source at once, no clock needed
   always_ff @(posedge ref_clk or posedge rst or posedge reset_source) begin
      if (rst || reset_source) begin
         port_rst_q <= 1'b1;
      end else begin
         port_rst_q <= int_rst_q;
      end
   end

   wire soft_rst = int_rst_q;
   wire clr_all  = rst;

   // =========================================
   // bus write channel
   logic       aw_hold_q, w_hold_q, bvalid_q;
   logic [7:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic       w_lane_q;
   logic [1:0] bresp_q;

   wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
   wire wr_mcu   = do_write && w_lane_q && aw_addr_q == sleep_power_pkg::off_mcu_control;
   wire wr_sleep = do_write && w_lane_q && aw_addr_q == sleep_power_pkg::off_sleep_mode;
   wire wr_gate  = do_write && w_lane_q && aw_addr_q == sleep_power_pkg::off_power_reduce;
   wire wr_known = aw_addr_q == sleep_power_pkg::off_mcu_control ||
                   aw_addr_q == sleep_power_pkg::off_sleep_mode ||
                   aw_addr_q == sleep_power_pkg::off_power_reduce ||
                   aw_addr_q == sleep_power_pkg::off_sleep_status;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 8'h00;
         w_lane_q  <= 1'b0;
         bresp_q   <= sleep_power_pkg::bus_okay;
      end else begin
         if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= {2'b00, s_axi_awaddr[7:2]};
         end
         if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
         end
         if (do_write) begin
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_known ? sleep_power_pkg::bus_okay : sleep_power_pkg::bus_decode_err;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // =========================================
   // control registers
   logic [7:0] sleep_ctrl_q;
   logic [7:0] gate_q;
   logic       pud_q;
   logic       det_en_q;
   logic [2:0] arm_cnt_q;
   logic       det_sleep_q;
   logic [2:0] det_cnt_q;
   logic       sleep_hold;

   wire mcu_arm    = wr_mcu && w_data_q[sleep_power_pkg::detector_sleep_pos] &&
                     w_data_q[sleep_power_pkg::detector_en_pos];
   wire mcu_commit = wr_mcu && det_en_q && w_data_q[sleep_power_pkg::detector_sleep_pos] &&
                     !w_data_q[sleep_power_pkg::detector_en_pos];
   wire det_active = det_sleep_q && det_cnt_q == '0;

   always_ff @(posedge ref_clk or posedge clr_all) begin
      if (clr_all) begin
         sleep_ctrl_q <= sleep_power_pkg::sleep_mode_rst;
         gate_q       <= sleep_power_pkg::power_red_rst;
         pud_q        <= 1'b0;
         det_en_q     <= 1'b0;
         arm_cnt_q    <= 3'h0;
         det_sleep_q  <= 1'b0;
         det_cnt_q    <= 3'h0;
      end else if (soft_rst) begin
         sleep_ctrl_q <= sleep_power_pkg::sleep_mode_rst;
         gate_q       <= sleep_power_pkg::power_red_rst;
         pud_q        <= 1'b0;
         det_en_q     <= 1'b0;
         arm_cnt_q    <= 3'h0;
         det_sleep_q  <= 1'b0;
         det_cnt_q    <= 3'h0;
      end else begin
         if (wr_sleep) sleep_ctrl_q <= w_data_q & sleep_power_pkg::sleep_mode_mask;
         if (wr_gate)  gate_q <= w_data_q & sleep_power_pkg::power_red_mask;
         if (wr_mcu)   pud_q <= w_data_q[sleep_power_pkg::pullup_disable_pos];
         if (mcu_arm) begin
            det_en_q  <= 1'b1;
            arm_cnt_q <= sleep_power_pkg::arm_window_cycles;
         end else if (mcu_commit || arm_cnt_q == 3'h1) begin
            det_en_q  <= 1'b0;
            arm_cnt_q <= 3'h0;
         end else if (arm_cnt_q != 3'h0) begin
            arm_cnt_q <= arm_cnt_q - 3'h1;
         end
         if (mcu_commit) begin
            det_sleep_q <= 1'b1;
            det_cnt_q   <= sleep_power_pkg::detector_on_cycles;
         end else if (det_cnt_q != 3'h0) begin
            det_cnt_q <= det_cnt_q - 3'h1;
         end else if (det_sleep_q && !sleep_hold) begin
            det_sleep_q <= 1'b0;
         end
      end
   end

   // =========================================
   // sleep sequencer
   sleep_power_pkg::power_state_type state_q;
   sleep_power_pkg::sleep_mode_type  mode_q;
   logic                             det_off_q;
   logic [stretch_width-1:0]         wait_q;

   wire [1:0] mode_field = sleep_ctrl_q[2:1];
   wire       go_sleep   = sleep_instr && sleep_ctrl_q[sleep_power_pkg::sleep_enable_pos] &&
                           mode_field != sleep_power_pkg::mode_rsvd;
   assign sleep_hold = state_q == sleep_power_pkg::st_run && go_sleep && det_active;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q   <= sleep_power_pkg::st_run;
         mode_q    <= sleep_power_pkg::mode_idle;
         det_off_q <= 1'b0;
         wait_q    <= '0;
      end else if (soft_rst) begin
         state_q   <= sleep_power_pkg::st_run;
         det_off_q <= 1'b0;
         wait_q    <= '0;
      end else begin
         unique case (state_q)
            sleep_power_pkg::st_run: if (go_sleep) begin
               state_q   <= sleep_power_pkg::st_sleep;
               mode_q    <= sleep_power_pkg::sleep_mode_type'(mode_field);
               det_off_q <= det_active;
            end
            sleep_power_pkg::st_sleep: if (wake_event) begin
               state_q <= sleep_power_pkg::st_startup;
               wait_q  <= fuse_startup_count;
            end
            sleep_power_pkg::st_startup: begin
               det_off_q <= 1'b0;
               if (wait_q == '0) begin
                  state_q <= sleep_power_pkg::st_halt;
                  wait_q  <= stretch_width'(sleep_power_pkg::wake_halt_cycles);
               end else begin
                  wait_q <= wait_q - 1'b1;
               end
            end
            sleep_power_pkg::st_halt: if (wait_q == stretch_width'(1)) begin
               state_q <= sleep_power_pkg::st_run;
            end else begin
               wait_q <= wait_q - 1'b1;
            end
         endcase
      end
   end

   wire asleep   = state_q == sleep_power_pkg::st_sleep;
   wire deep     = asleep && mode_q == sleep_power_pkg::mode_powerdn;
   wire io_stop  = asleep && mode_q != sleep_power_pkg::mode_idle;
   wire det_en_w = detector_level_fuses && !(asleep && det_off_q);
   wire cmp_en_w = comparator_enable && !gate_q[sleep_power_pkg::gate_conv_pos] &&
                   !(deep && !comparator_uses_ref);
   wire conv_en_w = converter_enable && !gate_q[sleep_power_pkg::gate_conv_pos];

   // =========================================
   // read channel
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   wire  [7:0]  ar_addr = {2'b00, s_axi_araddr[7:2]};
   wire  [7:0]  mcu_rd  = {1'b0, det_sleep_q, det_en_q, pud_q, 4'h0};
   wire  [7:0]  stat_rd = {4'h0, det_active, asleep, state_q};
   wire  [7:0]  rd_byte = ar_addr == sleep_power_pkg::off_mcu_control  ? mcu_rd :
                          ar_addr == sleep_power_pkg::off_sleep_mode   ? sleep_ctrl_q :
                          ar_addr == sleep_power_pkg::off_power_reduce ? gate_q :
                          ar_addr == sleep_power_pkg::off_sleep_status ? stat_rd : 8'h00;
   wire         rd_known = ar_addr == sleep_power_pkg::off_mcu_control ||
                           ar_addr == sleep_power_pkg::off_sleep_mode ||
                           ar_addr == sleep_power_pkg::off_power_reduce ||
                           ar_addr == sleep_power_pkg::off_sleep_status;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= sleep_power_pkg::bus_okay;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h00_0000, rd_byte};
         rresp_q  <= rd_known ? sleep_power_pkg::bus_okay : sleep_power_pkg::bus_decode_err;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // =========================================
   // registered outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         main_clock_run      <= 1'b1;
         io_clock_run        <= 1'b1;
         converter_clock_run <= 1'b1;
         watchdog_run        <= 1'b0;
         detector_on         <= 1'b0;
         comparator_on       <= 1'b0;
         reference_on        <= 1'b0;
         input_buffer_en     <= 8'hff;
         cpu_halt            <= 1'b1;
      end else begin
         main_clock_run      <= !deep || debug_enable_fuse;
         io_clock_run        <= !io_stop;
         converter_clock_run <= !deep;
         watchdog_run        <= watchdog_enable;
         detector_on         <= det_en_w;
         comparator_on       <= cmp_en_w;
         reference_on        <= det_en_w || (cmp_en_w && comparator_uses_ref) || conv_en_w;
         input_buffer_en     <= deep ? wake_pin_mask : 8'hff;
         cpu_halt            <= soft_rst || state_q != sleep_power_pkg::st_run;
      end
   end

   // gate outputs are the power reduction register bits, driven out directly
   assign gate_two_wire      = gate_q[sleep_power_pkg::gate_two_wire_pos];
   assign gate_timer_zero    = gate_q[sleep_power_pkg::gate_timer0_pos];
   assign gate_timer_one     = gate_q[sleep_power_pkg::gate_timer1_pos];
   assign gate_serial_periph = gate_q[sleep_power_pkg::gate_serial_pos];
   assign gate_converter     = gate_q[sleep_power_pkg::gate_conv_pos];
   assign pullup_disable     = pud_q;
   assign internal_reset     = int_rst_q;
   assign port_reset         = port_rst_q;
   assign s_axi_awready      = !aw_hold_q;
   assign s_axi_wready       = !w_hold_q;
   assign s_axi_bvalid       = bvalid_q;
   assign s_axi_bresp        = bresp_q;
   assign s_axi_arready      = !rvalid_q;
   assign s_axi_rvalid       = rvalid_q;
   assign s_axi_rdata        = rdata_q;
   assign s_axi_rresp        = rresp_q;

   // =========================================
   // checks
   chk_detector_window: assert property (@(posedge ref_clk) disable iff (rst)
      mcu_commit && !soft_rst |=> !det_active ##1 !det_active ##1 !det_active ##1 det_active)
      else $error("detector sleep not active three cycles after set");
   chk_arm_expiry: assert property (@(posedge ref_clk) disable iff (rst)
      mcu_arm && !soft_rst ##1 !wr_mcu [*4] |=> !det_en_q)
      else $error("enable did not clear after window");
   chk_reserved_noop: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == sleep_power_pkg::st_run && mode_field == sleep_power_pkg::mode_rsvd
      |=> state_q != sleep_power_pkg::st_sleep)
      else $error("reserved mode entered sleep");
   chk_sleep_enable: assert property (@(posedge ref_clk) disable iff (rst)
      state_q == sleep_power_pkg::st_run && !sleep_ctrl_q[0] |=> !asleep)
      else $error("sleep without enable");
   chk_mcu_zero: assert property (@(posedge ref_clk) disable iff (rst)
      s_axi_rvalid && ar_addr == sleep_power_pkg::off_mcu_control
      |-> {s_axi_rdata[7], s_axi_rdata[3:0]} == 5'h00)
      else $error("reserved mcu bits nonzero");
   chk_gate_zero: assert property (@(posedge ref_clk) disable iff (rst)
      (gate_q & ~sleep_power_pkg::power_red_mask) == 8'h00)
      else $error("reserved gate bits set");
   chk_reference: assert property (@(posedge ref_clk) disable iff (rst)
      !det_en_w && !cmp_en_w && !conv_en_w |=> !reference_on)
      else $error("reference on without user");
   chk_wake_halt: assert property (@(posedge ref_clk) disable iff (rst || soft_rst)
      state_q == sleep_power_pkg::st_startup && wait_q == '0
      |=> state_q == sleep_power_pkg::st_halt [*4] ##1 state_q == sleep_power_pkg::st_run)
      else $error("wake halt not four cycles");
   chk_comparator_gate: assert property (@(posedge ref_clk) disable iff (rst)
      gate_q[0] |=> !comparator_on)
      else $error("comparator on while converter gated");
endmodule

// file: rtl/sleep_power_pkg.sv
package sleep_power_pkg;
   // =========================================
   // register indices, byte address is four times the index
   localparam logic [7:0] off_mcu_control   = 8'h35;
   localparam logic [7:0] off_sleep_mode    = 8'h36;
   localparam logic [7:0] off_power_reduce  = 8'h37;
   localparam logic [7:0] off_sleep_status  = 8'h38;
   // =========================================
   // field positions
   localparam int sleep_enable_pos   = 0;
   localparam int sleep_mode_lo      = 1;
   localparam int detector_sleep_pos = 6;
   localparam int detector_en_pos    = 5;
   localparam int pullup_disable_pos = 4;
   localparam int gate_two_wire_pos  = 7;
   localparam int gate_timer0_pos    = 5;
   localparam int gate_timer1_pos    = 3;
   localparam int gate_serial_pos    = 2;
   localparam int gate_conv_pos      = 0;
   // =========================================
   // writable masks and reset values
   localparam logic [7:0] sleep_mode_mask = 8'h07;
   localparam logic [7:0] mcu_ctrl_mask   = 8'h70;
   localparam logic [7:0] power_red_mask  = 8'had;
   localparam logic [7:0] sleep_mode_rst  = 8'h00;
   localparam logic [7:0] mcu_ctrl_rst    = 8'h00;
   localparam logic [7:0] power_red_rst   = 8'h00;
   // =========================================
   // timing counts in cycles and bus response codes
   localparam logic [2:0] arm_window_cycles  = 3'h4;
   localparam logic [2:0] detector_on_cycles = 3'h3;
   localparam logic [2:0] wake_halt_cycles   = 3'h4;
   localparam logic [1:0] bus_okay           = 2'h0;
   localparam logic [1:0] bus_decode_err     = 2'h3;
   // =========================================
   typedef enum logic [1:0] {
      mode_idle    = 2'b00,
      mode_noise   = 2'b01,
      mode_powerdn = 2'b10,
      mode_rsvd    = 2'b11
   } sleep_mode_type;
   typedef enum logic [1:0] {
      st_run     = 2'b00,
      st_sleep   = 2'b01,
      st_startup = 2'b10,
      st_halt    = 2'b11
   } power_state_type;
endpackage

// file: dv/tb_sleep_power_reduction_ctrl.sv
`timescale 1ns/1ps
module tb_sleep_power_reduction_ctrl;
   // ==========
   // stimulus and observed outputs
   logic ref_clk = 1'b0, rst = 1'b1, reset_source = 1'b0, sleep_instr = 1'b0, wake_event = 1'b0;
   logic debug_enable_fuse = 1'b1, watchdog_enable = 1'b1, detector_level_fuses = 1'b1;
   logic comparator_enable = 1'b1, comparator_uses_ref = 1'b0, converter_enable = 1'b0;
   logic [15:0] fuse_stretch_count = 16'h0008, fuse_startup_count = 16'h0004;
   logic [7:0]  wake_pin_mask = 8'h0a, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic internal_reset, port_reset, cpu_halt, main_clock_run, io_clock_run;
   logic converter_clock_run, watchdog_run, detector_on, comparator_on, reference_on;
   logic [7:0] input_buffer_en;
   logic pullup_disable, gate_two_wire, gate_timer_zero, gate_timer_one, gate_serial_periph;
   logic gate_converter;
   int error_cnt = 0, comparisons = 0, cycles = 0;
   sleep_power_reduction_ctrl #(.stretch_width(16)) i_dut (.ref_clk, .rst, .reset_source,
      .fuse_stretch_count, .fuse_startup_count, .sleep_instr, .wake_event, .debug_enable_fuse,
      .watchdog_enable, .detector_level_fuses, .comparator_enable, .comparator_uses_ref,
      .converter_enable, .wake_pin_mask, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .internal_reset, .port_reset, .cpu_halt, .main_clock_run,
      .io_clock_run, .converter_clock_run, .watchdog_run, .detector_on, .comparator_on,
      .reference_on, .input_buffer_en, .pullup_disable, .gate_two_wire, .gate_timer_zero,
      .gate_timer_one, .gate_serial_periph, .gate_converter);
   always #50 ref_clk = ~ref_clk;
   // ==========
   // helpers
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic done;
      done = 1'b0;
      @(posedge ref_clk);
      s_axi_awaddr <= {a[5:0], 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge ref_clk);
      s_axi_araddr <= {a[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            s_axi_rready <= 1'b0;
            done = 1'b1;
            chk(nm, e, s_axi_rdata);
            chk({nm, " resp"}, {30'h0, r}, {30'h0, s_axi_rresp});
         end
      end
   endtask
   task automatic sleep_now();
      @(posedge ref_clk) sleep_instr <= 1'b1;
      @(posedge ref_clk) sleep_instr <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic wake_up();
      @(posedge ref_clk) wake_event <= 1'b1;
      @(posedge ref_clk) wake_event <= 1'b0;
      for (int i = 0; i < 40 && cpu_halt !== 1'b0; i++) @(posedge ref_clk);
   endtask
   task automatic wait_run();
      for (int i = 0; i < 60 && internal_reset !== 1'b0; i++) @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   // ==========
   // tests
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      wait_run();
      rd("mcu rst", sleep_power_pkg::off_mcu_control, 32'h0, 2'h0);
      rd("mode rst", sleep_power_pkg::off_sleep_mode, 32'h0, 2'h0);
      rd("gate rst", sleep_power_pkg::off_power_reduce, 32'h0, 2'h0);
      wr(sleep_power_pkg::off_mcu_control, 8'h9f);
      rd("mcu mask", sleep_power_pkg::off_mcu_control, 32'h10, 2'h0);
      chk("pullup", 32'h1, {31'h0, pullup_disable});
      wr(sleep_power_pkg::off_power_reduce, 8'hff);
      rd("gate mask", sleep_power_pkg::off_power_reduce, 32'had, 2'h0);
      @(posedge ref_clk);
      chk("gates", 32'h1f, {27'h0, gate_two_wire, gate_timer_zero, gate_timer_one,
          gate_serial_periph, gate_converter});
      chk("cmp gated", 32'h0, {31'h0, comparator_on});
      wr(sleep_power_pkg::off_power_reduce, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk("cmp ungated", 32'h1, {31'h0, comparator_on});
      rd("bad addr", 8'h80, 32'h0, sleep_power_pkg::bus_decode_err);
      wr(sleep_power_pkg::off_mcu_control, 8'h60);
      repeat (10) @(posedge ref_clk);
      rd("arm expiry", sleep_power_pkg::off_mcu_control, 32'h0, 2'h0);
      $display("test registers done");
      wr(sleep_power_pkg::off_sleep_mode, 8'hff);
      rd("mode mask", sleep_power_pkg::off_sleep_mode, 32'h07, 2'h0);
      sleep_now();
      chk("rsvd nop", 32'h0, {31'h0, cpu_halt});
      wr(sleep_power_pkg::off_sleep_mode, 8'h04);
      sleep_now();
      chk("no enable", 32'h0, {31'h0, cpu_halt});
      wr(sleep_power_pkg::off_sleep_mode, 8'h05);
      sleep_now();
      chk("asleep", 32'h1, {31'h0, cpu_halt});
      chk("buffers", 32'h0a, {24'h0, input_buffer_en});
      chk("cmp off", 32'h0, {31'h0, comparator_on});
      chk("states", 32'h0d, {27'h0, converter_clock_run, watchdog_run, detector_on,
          io_clock_run, main_clock_run});
      @(posedge ref_clk) wake_event <= 1'b1;
      @(posedge ref_clk) wake_event <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("wake halt", 32'h1, {31'h0, cpu_halt});
      for (int i = 0; i < 40 && cpu_halt !== 1'b0; i++) @(posedge ref_clk);
      chk("awake", 32'h0, {31'h0, cpu_halt});
      wr(sleep_power_pkg::off_sleep_mode, 8'h03);
      sleep_now();
      chk("noise outs", 32'h5ff, {21'h0, converter_clock_run, io_clock_run, comparator_on,
          input_buffer_en});
      rd("status", sleep_power_pkg::off_sleep_status, 32'h05, 2'h0);
      wake_up();
      wr(sleep_power_pkg::off_mcu_control, 8'h60);
      wr(sleep_power_pkg::off_mcu_control, 8'h40);
      @(posedge ref_clk);
      sleep_now();
      chk("det off", 32'h0, {31'h0, detector_on});
      wake_up();
      chk("det on", 32'h1, {31'h0, detector_on});
      rd("det clear", sleep_power_pkg::off_mcu_control, 32'h0, 2'h0);
      wr(sleep_power_pkg::off_sleep_mode, 8'h00);
      $display("test sleep done");
      wr(sleep_power_pkg::off_power_reduce, 8'had);
      @(posedge ref_clk) reset_source <= 1'b1;
      #10 chk("port rst", 32'h1, {31'h0, port_reset});
      repeat (3) @(posedge ref_clk);
      reset_source <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk("stretch", 32'h1, {31'h0, internal_reset});
      wait_run();
      rd("gate after rst", sleep_power_pkg::off_power_reduce, 32'h0, 2'h0);
      chk("ref on", 32'h1, {31'h0, reference_on});
      @(posedge ref_clk);
      detector_level_fuses <= 1'b0;
      comparator_enable <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("ref off", 32'h0, {31'h0, reference_on});
      $display("test reset done");
      end_sim();
   end
endmodule
